/* File: rtl/ddc_ctrl_regs.svh */
// Purpose: register map, field positions and constants of the ddc control
// Assumes: registers sit one per aligned word, byte address = index * 4
// Notes: included by the package and by the bench
//
// Functional notes
// - frame clock pattern register resets to 0xffc00
// - decimation bypass picks pattern from resolution
// - averaging outputs (a+b)/2 under documented conditions
// - input select routes split, a, b, average
// - bypass bit clear skips digital features
// - one enable switches decimation for both channels
// - input select acts only with mux enabled
// - decimation code 000 bypass, 001-101 by 2..32
// - real output bit selects real, else complex
// - phase invert bit inverts oscillator phase
// - channel a mixer gain 0, 3, 6 db
// - channel b mixer gain 0, 3, 6 db
// - toggling restart a resets channel a phase
// - toggling restart b resets channel b phase
// - quarter-rate mixing on downconverter a
// - quarter-rate mixing on downconverter b
`ifndef DDC_CTRL_REGS_SVH
`define DDC_CTRL_REGS_SVH

// ---------------------------------------------------------------
// register indices and address decode
// ---------------------------------------------------------------
`define FCP_IDX 8'h20
`define DPC_IDX 8'h24
`define DEC_IDX 8'h25
`define MIX_IDX 8'h26
`define STATUS_IDX 8'h28
`define EFFPAT_IDX 8'h29
`define IDX_HI 9
`define IDX_LO 2
`define ADDR_W 12

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define FCP_W 20
`define FCP_RESET 20'hffc00
`define PAT_14 20'hfe000
`define PAT_16 20'hff000
`define PAT_18 20'hff800
`define PAT_20 20'hffc00
`define CFG_RESET 8'h00
`define DPC_MASK 8'h3e
`define DEC_MASK 8'hf9
`define MIX_MASK 8'hff
`define AVG_EN_BIT 5
`define SEL_HI 4
`define SEL_LO 3
`define BYP_BIT 2
`define DEN_BIT 1
`define MUXEN_BIT 7
`define DEC_HI 6
`define DEC_LO 4
`define REAL_BIT 3
`define PHINV_BIT 0
`define GA_HI 7
`define GA_LO 6
`define RSA_BIT 5
`define Q4A_BIT 4
`define GB_HI 3
`define GB_LO 2
`define RSB_BIT 1
`define Q4B_BIT 0
`define DEC_MAX 3'h5
`define DEC_CNT_W 5
`define LANE_W 16
`define READY_MARGIN 3

`endif

/* File: rtl/ddc_ctrl_pkg.sv */
// Purpose: shared types of the ddc control
// Assumes: constants come from ddc_ctrl_regs.svh
// Notes: enum orders follow the register encodings
`include "ddc_ctrl_regs.svh"
package ddc_ctrl_pkg;
	typedef enum logic [1:0] {SEL_SPLIT, SEL_A, SEL_B, SEL_AVG} input_sel_t;
	typedef enum logic [1:0] {GAIN_0DB, GAIN_3DB, GAIN_6DB, GAIN_NONE} gain_t;
	typedef enum logic [1:0] {RES_14, RES_16, RES_18, RES_20} resolution_t;
	typedef enum logic [1:0] {QP_0, QP_90, QP_180, QP_270} quarter_phase_t;
	typedef struct packed {
		logic signed [`LANE_W-1:0] i;
		logic signed [`LANE_W-1:0] q;
	} iq_t;
	typedef struct packed {
		iq_t a;
		iq_t b;
	} lane_set_t;
endpackage

/* File: rtl/ddc_control.sv */
// Purpose: configuration and sample path of the dual downconverter
// Assumes: samples arrive on pclk, registers over apb
// Notes: holds the output fifo module and the top module
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// output fifo
// ---------------------------------------------------------------
module sample_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire wr_last = wr_ptr == PW'(DEPTH - 1);
	wire rd_last = rd_ptr == PW'(DEPTH - 1);

	assign in_ready = level != LW'(DEPTH);
	assign out_valid = level != '0;
	assign out_data = mem[rd_ptr];

	for (genvar e = 0; e < DEPTH; e++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				mem[e] <= '0;
			else if (push && wr_ptr == PW'(e))
				mem[e] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_last ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_last ? '0 : rd_ptr + 1'b1;
			level <= level + LW'(push) - LW'(pop);
		end
	end
endmodule

// ---------------------------------------------------------------
// top
// ---------------------------------------------------------------
module ddc_control #(
	parameter int W = 14,
	parameter int DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [W-1:0] sample_a,
	input wire logic signed [W-1:0] sample_b,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire ddc_ctrl_pkg::resolution_t output_resolution,
	output ddc_ctrl_pkg::lane_set_t out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic frame_clock
);
	import ddc_ctrl_pkg::*;
	localparam int LW = $clog2(DEPTH+1);

	// ---------------------------------------------------------------
	// register bus decode
	// ---------------------------------------------------------------
	logic [`FCP_W-1:0] frame_clock_pattern;
	logic [7:0] digital_path_config;
	logic [7:0] decimation_config;
	logic [7:0] mixer_config;
	logic [`FCP_W-1:0] eff_pattern;
	logic [LW-1:0] fifo_level;
	logic pat_bypass;
	logic avg_active;

	wire [7:0] idx = paddr[`IDX_HI:`IDX_LO];
	wire aligned = paddr[`IDX_LO-1:0] == '0;
	wire in_page = paddr[`ADDR_W-1:`IDX_HI+1] == '0;
	wire hit_fcp = idx == `FCP_IDX;
	wire hit_dpc = idx == `DPC_IDX;
	wire hit_dec = idx == `DEC_IDX;
	wire hit_mix = idx == `MIX_IDX;
	wire hit_sts = idx == `STATUS_IDX;
	wire hit_eff = idx == `EFFPAT_IDX;
	wire any_hit = hit_fcp | hit_dpc | hit_dec | hit_mix | hit_sts | hit_eff;
	wire mapped = aligned & in_page & any_hit;
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready & pwrite & mapped;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k])
				r[8*k +: 8] = nw[8*k +: 8];
		end
		return r;
	endfunction

	wire [31:0] fcp_word = 32'(frame_clock_pattern);
	wire [31:0] fcp_next = merge(fcp_word, pwdata, pstrb);
	wire [7:0] dpc_next = pstrb[0] ? pwdata[7:0] & `DPC_MASK
		: digital_path_config;
	wire [7:0] dec_next = pstrb[0] ? pwdata[7:0] & `DEC_MASK
		: decimation_config;
	wire [7:0] mix_next = pstrb[0] ? pwdata[7:0] & `MIX_MASK
		: mixer_config;
	wire [31:0] sts_word = {22'h0, avg_active, pat_bypass,
		8'(fifo_level)};
	wire [31:0] rd_word = hit_fcp ? fcp_word
		: hit_dpc ? 32'(digital_path_config)
		: hit_dec ? 32'(decimation_config)
		: hit_mix ? 32'(mixer_config)
		: hit_sts ? sts_word
		: hit_eff ? 32'(eff_pattern) : 32'h00000000;

	// one wait-free access phase: pready is up during every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite & mapped) ? rd_word : '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_clock_pattern <= `FCP_RESET;
			digital_path_config <= `CFG_RESET;
			decimation_config <= `CFG_RESET;
			mixer_config <= `CFG_RESET;
		end else if (wr) begin
			if (hit_fcp)
				frame_clock_pattern <= fcp_next[`FCP_W-1:0];
			if (hit_dpc)
				digital_path_config <= dpc_next;
			if (hit_dec)
				decimation_config <= dec_next;
			if (hit_mix)
				mixer_config <= mix_next;
		end
	end

	// ---------------------------------------------------------------
	// configuration fields
	// ---------------------------------------------------------------
	wire avg_en = digital_path_config[`AVG_EN_BIT];
	wire [1:0] sel_raw = digital_path_config[`SEL_HI:`SEL_LO];
	wire features = digital_path_config[`BYP_BIT];
	wire downconverter_enable = digital_path_config[`DEN_BIT];
	wire mux_en = decimation_config[`MUXEN_BIT];
	wire [2:0] dec_code = decimation_config[`DEC_HI:`DEC_LO];
	wire real_out = decimation_config[`REAL_BIT];
	wire phase_inv = decimation_config[`PHINV_BIT];
	wire [1:0] gain_a = mixer_config[`GA_HI:`GA_LO];
	wire restart_a = mixer_config[`RSA_BIT];
	wire q4_a = mixer_config[`Q4A_BIT];
	wire [1:0] gain_b = mixer_config[`GB_HI:`GB_LO];
	wire restart_b = mixer_config[`RSB_BIT];
	wire q4_b = mixer_config[`Q4B_BIT];

	// ---------------------------------------------------------------
	// input mux and averaging
	// ---------------------------------------------------------------
	input_sel_t sel_eff;
	assign sel_eff = mux_en ? input_sel_t'(sel_raw) : SEL_SPLIT;
	wire use_avg = sel_eff == SEL_AVG && avg_en;
	wire signed [`LANE_W-1:0] ext_a = `LANE_W'(sample_a);
	wire signed [`LANE_W-1:0] ext_b = `LANE_W'(sample_b);
	wire signed [`LANE_W-1:0] sum_ab = ext_a + ext_b;
	wire signed [`LANE_W-1:0] avg_ab = sum_ab >>> 1;
	// sel 11 without averaging enabled falls back to the split routing
	wire signed [`LANE_W-1:0] route_a = sel_eff == SEL_B ? ext_b
		: use_avg ? avg_ab : ext_a;
	wire signed [`LANE_W-1:0] route_b = sel_eff == SEL_A ? ext_a
		: use_avg ? avg_ab : ext_b;
	assign avg_active = use_avg & downconverter_enable & features;

	// ---------------------------------------------------------------
	// mixer: quarter-rate oscillator, phase invert and gain
	// ---------------------------------------------------------------
	quarter_phase_t phase_a;
	quarter_phase_t phase_b;
	logic restart_a_seen;
	logic restart_b_seen;

	function automatic iq_t quarter_mix(input logic signed [`LANE_W-1:0] x,
		input quarter_phase_t ph, input logic en, input logic inv);
		iq_t r;
		r.i = x;
		r.q = '0;
		if (en) begin
			unique case (ph)
				QP_0: r.i = x;
				QP_90: begin
					r.i = '0;
					r.q = -x;
				end
				QP_180: r.i = -x;
				QP_270: begin
					r.i = '0;
					r.q = x;
				end
			endcase
		end
		if (inv)
			r.q = -r.q;
		return r;
	endfunction

	function automatic logic signed [`LANE_W-1:0] apply_gain(
		input logic signed [`LANE_W-1:0] x, input logic [1:0] g);
		logic signed [`LANE_W-1:0] r;
		r = x;
		unique case (gain_t'(g))
			GAIN_0DB: r = x;
			GAIN_3DB: r = x + (x >>> 2) + (x >>> 3);
			GAIN_6DB: r = x <<< 1;
			GAIN_NONE: r = x;
		endcase
		return r;
	endfunction

	wire dec_valid = dec_code != '0 && dec_code <= `DEC_MAX;
	wire dec_on = features & downconverter_enable & dec_valid;
	wire mix_on = features & downconverter_enable & ~real_out;
	iq_t mix_a;
	iq_t mix_b;
	assign mix_a = quarter_mix(route_a, phase_a, q4_a, phase_inv);
	assign mix_b = quarter_mix(route_b, phase_b, q4_b, phase_inv);
	iq_t gmix_a;
	iq_t gmix_b;
	assign gmix_a = '{i: apply_gain(mix_a.i, gain_a),
		q: apply_gain(mix_a.q, gain_a)};
	assign gmix_b = '{i: apply_gain(mix_b.i, gain_b),
		q: apply_gain(mix_b.q, gain_b)};
	lane_set_t lanes;
	assign lanes = !features
		? lane_set_t'{a: '{ext_a, '0}, b: '{ext_b, '0}}
		: mix_on ? lane_set_t'{a: gmix_a, b: gmix_b}
		: lane_set_t'{a: '{route_a, '0}, b: '{route_b, '0}};

	// ---------------------------------------------------------------
	// decimation and sample stage
	// ---------------------------------------------------------------
	logic [`DEC_CNT_W-1:0] dec_cnt;
	lane_set_t stage;
	logic stage_valid;
	logic fifo_in_ready;
	wire [`DEC_CNT_W:0] ratio = (`DEC_CNT_W+1)'(1) << dec_code;
	wire [`DEC_CNT_W-1:0] ratio_m1 = `DEC_CNT_W'(ratio - 1'b1);
	wire take = sample_valid & sample_ready;
	wire emit = !dec_on || dec_cnt == ratio_m1;
	wire rs_a_tog = restart_a != restart_a_seen;
	wire rs_b_tog = restart_b != restart_b_seen;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_cnt <= '0;
			phase_a <= QP_0;
			phase_b <= QP_0;
			restart_a_seen <= 1'b0;
			restart_b_seen <= 1'b0;
		end else begin
			restart_a_seen <= restart_a;
			restart_b_seen <= restart_b;
			if (!dec_on)
				dec_cnt <= '0;
			else if (take)
				dec_cnt <= emit ? '0 : dec_cnt + 1'b1;
			if (rs_a_tog)
				phase_a <= QP_0;
			else if (take)
				phase_a <= quarter_phase_t'(phase_a + 2'b01);
			if (rs_b_tog)
				phase_b <= QP_0;
			else if (take)
				phase_b <= quarter_phase_t'(phase_b + 2'b01);
		end
	end

	// stage drains whenever the fifo has room; sample_ready follows the fifo margin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage <= '0;
			stage_valid <= 1'b0;
			sample_ready <= 1'b0;
		end else begin
			if (take && emit) begin
				stage <= lanes;
				stage_valid <= 1'b1;
			end else if (fifo_in_ready) begin
				stage_valid <= 1'b0;
			end
			sample_ready <= fifo_level < LW'(DEPTH - `READY_MARGIN);
		end
	end

	sample_fifo #(
		.WIDTH($bits(lane_set_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(stage_valid),
		.in_ready(fifo_in_ready),
		.in_data(stage),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data),
		.level(fifo_level)
	);

	// ---------------------------------------------------------------
	// frame clock pattern
	// ---------------------------------------------------------------
	logic [4:0] fc_idx;
	logic [`FCP_W-1:0] auto_pat;
	assign pat_bypass = ~dec_on;
	always_comb begin
		unique case (output_resolution)
			RES_14: auto_pat = `PAT_14;
			RES_16: auto_pat = `PAT_16;
			RES_18: auto_pat = `PAT_18;
			RES_20: auto_pat = `PAT_20;
		endcase
	end
	wire fc_last = fc_idx == 5'(`FCP_W - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eff_pattern <= `FCP_RESET;
			fc_idx <= '0;
			frame_clock <= 1'b0;
		end else begin
			eff_pattern <= pat_bypass ? auto_pat : frame_clock_pattern;
			fc_idx <= fc_last ? '0 : fc_idx + 1'b1;
			frame_clock <= eff_pattern[5'(`FCP_W - 1) - fc_idx];
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_auto_pattern: assert property (@(posedge pclk) disable iff (!presetn)
		presetn && !dec_on |=> eff_pattern == $past(auto_pat))
		else $error("bypass pattern not taken from resolution");
	a_manual_pattern: assert property (@(posedge pclk) disable iff (!presetn)
		dec_on |=> eff_pattern == $past(frame_clock_pattern))
		else $error("manual pattern not used in decimation");
	a_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(restart_a) |-> ##1 phase_a == QP_0)
		else $error("channel a phase not reset on toggle");
	a_restart_b: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(restart_b) |-> ##1 phase_b == QP_0)
		else $error("channel b phase not reset on toggle");
	a_path_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		take && !features |=> stage_valid && stage.a.i == $past(ext_a)
			&& stage.b.i == $past(ext_b))
		else $error("bypassed sample altered");
	a_mux_off: assert property (@(posedge pclk) disable iff (!presetn)
		take && features && !mux_en && downconverter_enable && real_out && !dec_on
			|=> stage.a.i == $past(ext_a) && stage.b.i == $past(ext_b))
		else $error("disabled mux changed routing");
	a_real_q: assert property (@(posedge pclk) disable iff (!presetn)
		take && emit && features && real_out |=> stage.a.q == '0
			&& stage.b.q == '0)
		else $error("real decimation produced imaginary part");
	a_avg_route: assert property (@(posedge pclk) disable iff (!presetn)
		take && avg_active && real_out && !dec_on
			|=> stage.a.i == stage.b.i
			&& stage.a.i == ($past(sum_ab) >>> 1))
		else $error("average not routed to both");
	a_dec_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		take && dec_on && dec_cnt != ratio_m1 |=> $stable(stage))
		else $error("decimator emitted early");
	a_ready_margin: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_level >= LW'(DEPTH - `READY_MARGIN) |=> !sample_ready)
		else $error("ready held with fifo nearly full");
	a_q4_off: assert property (@(posedge pclk) disable iff (!presetn)
		take && emit && mix_on && !q4_a && !q4_b |=> stage.a.q == '0
			&& stage.b.q == '0)
		else $error("quarter mixing active while disabled");
	a_gain_6db: assert property (@(posedge pclk) disable iff (!presetn)
		take && emit && mix_on && !q4_a && gain_a == 2'b10
			|=> stage.a.i == ($past(route_a) <<< 1))
		else $error("channel a gain wrong");
	a_gain_b_none: assert property (@(posedge pclk) disable iff (!presetn)
		take && emit && mix_on && !q4_b && gain_b == 2'b00
			|=> stage.b.i == $past(route_b))
		else $error("channel b gain wrong");
	a_inv_q: assert property (@(posedge pclk) disable iff (!presetn)
		take && emit && mix_on && q4_a && phase_a == QP_90 && gain_a == 2'b00
			|=> stage.a.q == ($past(phase_inv) ? $past(route_a)
			: -$past(route_a)))
		else $error("phase invert not applied");
endmodule

`default_nettype wire

/* File: sim/sample_sink.sv */
// Purpose: host side capture of the output words
// Assumes: a word is taken on an edge with out_valid and out_ready high
// Notes: stall holds ready low, slow gives ready every other cycle
`timescale 1ns/10ps
`default_nettype none
module sample_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall,
	input wire logic slow,
	input wire ddc_ctrl_pkg::lane_set_t out_data,
	input wire logic out_valid,
	output logic out_ready
);
	import ddc_ctrl_pkg::*;
	lane_set_t got[$];
	logic phase;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ready <= 1'b0;
			phase <= 1'b0;
		end else begin
			if (out_valid && out_ready)
				got.push_back(out_data);
			phase <= ~phase;
			out_ready <= !stall && !(slow && phase);
		end
	end
endmodule
`default_nettype wire

/* File: sim/dual_channel_ddc_control_bench.sv */
// Purpose: self-checking bench of the ddc control block
// Assumes: apb slave answers by itself; sink drains the fifo
// Notes: expectations come from the register encodings
`timescale 1ns/10ps
`default_nettype none
`include "ddc_ctrl_regs.svh"
module dual_channel_ddc_control_bench;
	import ddc_ctrl_pkg::*;
	localparam logic [11:0] A_PAT = 12'h080;
	localparam logic [11:0] A_DPC = 12'h090;
	localparam logic [11:0] A_DEC = 12'h094;
	localparam logic [11:0] A_MIX = 12'h098;
	localparam logic [11:0] A_STA = 12'h0a0;
	localparam logic [11:0] A_EFF = 12'h0a4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic signed [13:0] sample_a = 14'h0;
	logic signed [13:0] sample_b = 14'h0;
	logic sample_valid = 1'b0;
	logic sample_ready;
	resolution_t output_resolution = RES_14;
	lane_set_t out_data;
	logic out_valid;
	logic out_ready;
	logic frame_clock;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int check_count = 0;

	ddc_control #(.W(14), .DEPTH(32)) ddc_control_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .sample_a, .sample_b,
		.sample_valid, .sample_ready, .output_resolution, .out_data,
		.out_valid, .out_ready, .frame_clock
	);
	sample_sink sample_sink_i (
		.pclk, .presetn, .stall, .slow, .out_data, .out_valid, .out_ready
	);

	always #10 pclk = ~pclk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic timed_out();
		num_errors++;
		$display("wait ran out of cycles");
		report_and_stop();
	endtask

	task automatic chk32(string what, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_lane(string what, lane_set_t e, lane_set_t g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			timed_out();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(string what, logic [11:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk32(what, e, rd);
	endtask

	task automatic put(int a, int b);
		int n;
		sample_a <= 14'(a);
		sample_b <= 14'(b);
		sample_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sample_ready !== 1'b1 && n < 200);
		if (sample_ready !== 1'b1)
			timed_out();
	endtask

	function automatic lane_set_t mk(int ai, int aq, int bi, int bq);
		return lane_set_t'({16'(ai), 16'(aq), 16'(bi), 16'(bq)});
	endfunction

	task automatic get(lane_set_t e);
		int n;
		for (n = 0; n < 100 && sample_sink_i.got.size() == 0; n++)
			@(posedge pclk);
		if (sample_sink_i.got.size() == 0)
			timed_out();
		chk_lane("word", e, sample_sink_i.got.pop_front());
	endtask

	task automatic ones(logic [19:0] p);
		logic [31:0] k;
		k = 32'h0;
		repeat (20) @(posedge pclk);
		repeat (20) begin
			@(posedge pclk);
			k = k + frame_clock;
		end
		chk32("frame ones", $countones(p), k);
	endtask

	task automatic one(logic [7:0] dpc, logic [7:0] dec, logic [7:0] mix,
			lane_set_t e);
		wr(A_DPC, {24'h0, dpc});
		wr(A_DEC, {24'h0, dec});
		wr(A_MIX, {24'h0, mix});
		put(100, -50);
		sample_valid <= 1'b0;
		get(e);
	endtask

	task automatic decim(logic [7:0] dpc, int k, int sent, int kept);
		int n;
		wr(A_DPC, {24'h0, dpc});
		wr(A_DEC, 32'h08);
		wr(A_DEC, 32'(8 + k * 16));
		sample_sink_i.got.delete();
		for (n = 0; n < sent; n++)
			put(n, n);
		sample_valid <= 1'b0;
		repeat (10) @(posedge pclk);
		chk32("kept", kept, sample_sink_i.got.size());
		sample_sink_i.got.delete();
	endtask

	task automatic quarter(logic [7:0] dec, logic [7:0] mix, int s);
		int n;
		int ci[4] = '{1, 0, -1, 0};
		int cq[4] = '{0, -1, 0, 1};
		wr(A_DPC, 32'h06);
		wr(A_DEC, {24'h0, dec});
		wr(A_MIX, {24'h0, mix});
		repeat (2) @(posedge pclk);
		for (n = 0; n < 4; n++)
			put(64, 32);
		sample_valid <= 1'b0;
		for (n = 0; n < 4; n++)
			get(mk(64 * ci[n], 64 * s * cq[n], 32 * ci[n], 32 * s * cq[n]));
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdchk("pattern", A_PAT, 32'h000ffc00);
		rdchk("eff pattern", A_EFF, 32'h000fe000);
		rdchk("path", A_DPC, 32'h0);
		rdchk("decim", A_DEC, 32'h0);
		rdchk("mixer", A_MIX, 32'h0);
		wr(A_DPC, 32'hff);
		rdchk("path mask", A_DPC, 32'h3e);
		wr(A_DEC, 32'hff);
		rdchk("decim mask", A_DEC, 32'hf9);
		apb(1'b1, 12'h040, 32'hff);
		chk32("unmapped", 32'h1, {31'h0, err});
		apb(1'b0, 12'h082, 32'h0);
		chk32("misaligned", 32'h1, {31'h0, err});
		wr(A_DPC, 32'h0);
		wr(A_DEC, 32'h0);
		$display("registers done");
	endtask

	task automatic t_pattern();
		logic [19:0] tab[4] = '{20'hfe000, 20'hff000, 20'hff800, 20'hffc00};
		int r;
		wr(A_PAT, 32'hfffff);
		for (r = 0; r < 4; r++) begin
			output_resolution <= resolution_t'(r);
			rdchk("auto pattern", A_EFF, {12'h0, tab[r]});
			ones(tab[r]);
		end
		apb(1'b0, A_STA, 32'h0);
		chk32("auto flag", 32'h1, {31'h0, rd[8]});
		wr(A_DPC, 32'h06);
		wr(A_DEC, 32'h10);
		rdchk("manual pattern", A_EFF, 32'h000fffff);
		ones(20'hfffff);
		wr(A_PAT, 32'hfe000);
		rdchk("manual pattern", A_EFF, 32'h000fe000);
		wr(A_PAT, 32'hffc00);
		$display("pattern done");
	endtask

	task automatic t_route();
		one(8'h00, 8'h00, 8'h90, mk(100, 0, -50, 0));
		one(8'h06, 8'h88, 8'h00, mk(100, 0, -50, 0));
		one(8'h0e, 8'h88, 8'h00, mk(100, 0, 100, 0));
		one(8'h16, 8'h88, 8'h00, mk(-50, 0, -50, 0));
		one(8'h3e, 8'h88, 8'h00, mk(25, 0, 25, 0));
		one(8'h16, 8'h08, 8'h00, mk(100, 0, -50, 0));
		one(8'h06, 8'h08, 8'h50, mk(100, 0, -50, 0));
		one(8'h06, 8'h00, 8'h48, mk(137, 0, -100, 0));
		one(8'h06, 8'h00, 8'h84, mk(200, 0, -70, 0));
		one(8'h06, 8'h00, 8'h80, mk(200, 0, -50, 0));
		one(8'h06, 8'h00, 8'hcc, mk(100, 0, -50, 0));
		$display("route and gain done");
	endtask

	task automatic t_decim();
		int k;
		for (k = 1; k < 6; k++)
			decim(8'h06, k, 2 << k, 2);
		decim(8'h06, 0, 4, 4);
		decim(8'h06, 6, 4, 4);
		decim(8'h04, 1, 4, 4);
		$display("decimation done");
	endtask

	task automatic t_mix();
		quarter(8'h00, 8'h33, 1);
		quarter(8'h01, 8'h11, -1);
		wr(A_MIX, 32'h0);
		$display("mixing done");
	endtask

	task automatic t_fifo();
		int n;
		int taken;
		wr(A_DPC, 32'h0);
		wr(A_DEC, 32'h0);
		stall <= 1'b1;
		repeat (3) @(posedge pclk);
		sample_sink_i.got.delete();
		taken = 0;
		sample_valid <= 1'b1;
		for (n = 0; n < 60; n++) begin
			sample_a <= 14'(taken);
			@(posedge pclk);
			if (sample_ready === 1'b1)
				taken++;
		end
		sample_valid <= 1'b0;
		chk32("full", 32'h1, {31'h0, taken >= 29 && taken <= 32});
		repeat (5) @(posedge pclk);
		apb(1'b0, A_STA, 32'h0);
		chk32("level", taken, {24'h0, rd[7:0]});
		stall <= 1'b0;
		slow <= 1'b1;
		for (n = 0; n < 200 && sample_sink_i.got.size() < taken; n++)
			@(posedge pclk);
		chk32("drained", taken, sample_sink_i.got.size());
		chk32("first", 32'h0, 32'(sample_sink_i.got[0].a.i));
		chk32("last", taken - 1, 32'(sample_sink_i.got[taken - 1].a.i));
		repeat (2) @(posedge pclk);
		chk32("empty", 32'h0, {31'h0, out_valid});
		slow <= 1'b0;
		$display("fifo done");
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pattern();
		t_route();
		t_decim();
		t_mix();
		t_fifo();
		report_and_stop();
	end
endmodule
`default_nettype wire
